// ==== bench/drive_model.sv ====
// Drive side pin model: locked clock, read strobe and di-bit trains
`timescale 1ns/1ps
module drive_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Train request
	input  wire logic        go,
	input  wire logic [1:0]  pin_sel,
	input  wire logic [15:0] count,
	output logic             busy,
	// Drive pins
	output logic             locked_clock_in,
	output logic             read_strobe_in,
	output logic             dibit_pulse_in
);
	logic [15:0] left;
	logic [2:0]  ph;
	logic        high;

	// Two high, two low: the synchroniser still sees every edge, and the run stays short
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			busy <= 1'b0;
			left <= 16'h0000;
			ph <= 3'h0;
		end else if (go && !busy) begin
			busy <= (count != 16'h0000);
			left <= count;
			ph <= 3'h0;
		end else if (busy) begin
			ph <= (ph == 3'h3) ? 3'h0 : ph + 3'h1;
			if (ph == 3'h3) begin
				left <= left - 16'h0001;
				busy <= (left != 16'h0001);
			end
		end
	end

	// Pins rest low between trains
	assign high = busy && (ph < 3'h2);
	assign locked_clock_in = high && (pin_sel == 2'h0);
	assign read_strobe_in = high && (pin_sel == 2'h1);
	assign dibit_pulse_in = high && (pin_sel == 2'h2);
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench of the sector timing core
`timescale 1ns/1ps
`include "sector_timing_map.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
	$display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tb_top;
	logic        sys_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, go, busy;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [1:0]  pin_sel;
	logic [15:0] count;
	logic        locked_clock_in, read_strobe_in, dibit_pulse_in, write_strobe_out;
	logic        serial_shift_clock, word_handshake_clock_n, handshake_enable;
	logic        read_path_select, bit_zero_tick, byte_tick, sync_byte_count_a;
	logic        sync_byte_count_b, sector_pulse, sector_match, sector_located;
	logic [4:0]  current_sector_count;
	logic        data_field_end_count, end_of_block_tick;
	logic        hs_q, ws_q;
	logic [9:0]  ev;
	int          cnt [10];
	int          bad_count, checks, cyc_count;

	sector_timing i_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.locked_clock_in(locked_clock_in), .read_strobe_in(read_strobe_in),
		.dibit_pulse_in(dibit_pulse_in), .write_strobe_out(write_strobe_out),
		.serial_shift_clock(serial_shift_clock), .word_handshake_clock_n(word_handshake_clock_n),
		.handshake_enable(handshake_enable), .read_path_select(read_path_select),
		.bit_zero_tick(bit_zero_tick), .byte_tick(byte_tick),
		.sync_byte_count_a(sync_byte_count_a), .sync_byte_count_b(sync_byte_count_b),
		.data_field_end_count(data_field_end_count), .end_of_block_tick(end_of_block_tick),
		.sector_pulse(sector_pulse),
		.current_sector_count(current_sector_count), .sector_match(sector_match),
		.sector_located(sector_located));
	drive_model i_drive (.sys_clk(sys_clk), .rstn(rstn), .go(go), .pin_sel(pin_sel),
		.count(count), .busy(busy), .locked_clock_in(locked_clock_in),
		.read_strobe_in(read_strobe_in), .dibit_pulse_in(dibit_pulse_in));

	// ----------------------------------------
	// Clock, event counters, hang guard
	// ----------------------------------------
	always #4 sys_clk = ~sys_clk;
	assign ev = {serial_shift_clock, hs_q & ~word_handshake_clock_n, byte_tick, bit_zero_tick,
		sync_byte_count_a, sync_byte_count_b, sector_pulse, ws_q ^ write_strobe_out,
		data_field_end_count, end_of_block_tick};
	always @(posedge sys_clk) begin
		hs_q <= word_handshake_clock_n;
		ws_q <= write_strobe_out;
		for (int i = 0; i < 10; i++)
			cnt[i] <= rstn ? cnt[i] + int'(ev[9 - i]) : 0;
		cyc_count++;
		if (cyc_count == 90000) begin
			bad_count++;
			test_done();
		end
	end

	task automatic test_done();
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		// A write lands at the ack edge; let it settle before callers look
		@(posedge sys_clk);
	endtask

	// Settle margin covers the pin synchroniser delay
	task automatic pins(input logic [1:0] p, input int n);
		@(posedge sys_clk);
		pin_sel <= p;
		count <= 16'(n);
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		@(posedge sys_clk);
		while (busy) @(posedge sys_clk);
		repeat (8) @(posedge sys_clk);
	endtask

	task automatic do_reset();
		rstn <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
	endtask

	// Command, field, short format, read path, shift ticks, handshake pulses, sync flags
	task automatic row(input logic [2:0] c, input logic [1:0] f, input logic s,
		input logic rp, input int n, input int hs, input int sa, input int sb);
		do_reset();
		wb(1'b1, `ADR_OFFSET, {19'h0, s, 12'h000});
		wb(1'b1, `ADR_CTRL, {26'h0, f, 1'b0, c});
		`CHK(read_path_select, rp)
		pins(rp ? 2'h0 : 2'h1, 8);
		`CHK(cnt[0], 0)
		pins(rp ? 2'h1 : 2'h0, n);
		`CHK(cnt[0], n)
		`CHK(cnt[7], rp ? 8 : n)
		`CHK(cnt[1], hs)
		`CHK(cnt[2], n / 8)
		`CHK(cnt[3], n / 8)
		`CHK(cnt[4], sa)
		`CHK(cnt[5], sb)
		`CHK(cnt[8], int'(n / 8 > (s ? `BYTE_END16 : `BYTE_END18)))
		`CHK(cnt[9], int'(n / 8 > (s ? `BYTE_END16 + 7 : `BYTE_END18 + 7)))
		wb(1'b0, `ADR_STATUS, 32'h0);
		`CHK(q[25:16], 10'(n / 8))
	endtask

	initial begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, go} = 4'h0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hf;
		pin_sel = 2'h0;
		count = 16'h0;
		bad_count = 0;
		checks = 0;
		cyc_count = 0;
		do_reset();
		`CHK(word_handshake_clock_n, 1'b1)
		`CHK(handshake_enable, 1'b0)
		wb(1'b0, `ADR_STATUS, 32'h0);
		`CHK(q, 32'h0000_0100)
		wb(1'b1, `ADR_DESIRED, 32'h15);
		wb(1'b0, `ADR_DESIRED, 32'h0);
		`CHK(q, 32'h15)
		wb(1'b0, 8'h14, 32'h0);
		`CHK(q, 32'h0)
		row(3'h1, 2'h1, 1'b1, 1'b0, 96, 4, 0, 0);
		row(3'h2, 2'h2, 1'b0, 1'b0, 72, 3, 0, 0);
		row(3'h2, 2'h2, 1'b1, 1'b0, 72, 4, 0, 0);
		row(3'h3, 2'h1, 1'b1, 1'b1, 80, 4, 0, 0);
		row(3'h4, 2'h1, 1'b1, 1'b1, 80, 0, 0, 0);
		row(3'h4, 2'h2, 1'b1, 1'b1, 80, 4, 0, 0);
		row(3'h2, 2'h1, 1'b1, 1'b1, 80, 0, 0, 0);
		row(3'h1, 2'h1, 1'b1, 1'b0, 328, 4, 1, 1);
		row(3'h1, 2'h1, 1'b0, 1'b0, 296, 4, 1, 0);
		row(3'h2, 2'h2, 1'b1, 1'b0, 4152, 259, 1, 1);
		// Sector walk: byte count set up first so the sector clear shows
		do_reset();
		wb(1'b1, `ADR_OFFSET, 32'h1000);
		wb(1'b1, `ADR_DESIRED, 32'h01);
		wb(1'b1, `ADR_CTRL, 32'h11);
		pins(2'h0, 16);
		pins(2'h2, 608);
		`CHK(cnt[6], 0)
		pins(2'h2, 1);
		`CHK(cnt[6], 1)
		`CHK(current_sector_count, 5'h01)
		`CHK(sector_match, 1'b1)
		`CHK(sector_located, 1'b1)
		wb(1'b0, `ADR_STATUS, 32'h0);
		`CHK(q[25:16], 10'h000)
		wb(1'b0, `ADR_EVENTS, 32'h0);
		`CHK(q[1], 1'b1)
		wb(1'b1, `ADR_EVENTS, 32'h2);
		wb(1'b0, `ADR_EVENTS, 32'h0);
		`CHK(q[1], 1'b0)
		pins(2'h2, 609);
		`CHK(current_sector_count, 5'h02)
		`CHK(sector_located, 1'b0)
		pins(2'h2, 609 * 20);
		`CHK(current_sector_count, 5'h00)
		`CHK(cnt[6], 22)
		test_done();
	end
endmodule

// ==== common/sector_timing_map.svh ====
// Register offsets, field positions and counts of the sector timing core
`ifndef SECTOR_TIMING_MAP_SVH
`define SECTOR_TIMING_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADR_CTRL        8'h00
`define ADR_OFFSET      8'h04
`define ADR_DESIRED     8'h08
`define ADR_STATUS      8'h0c
`define ADR_EVENTS      8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_CMD_LSB    0
`define CTRL_FIELD_LSB  4
`define OFS_SHORT_BIT   12
`define ST_MATCH_BIT    8
`define ST_LOCATED_BIT  9
`define ST_HS_EN_BIT    10
`define ST_RD_PATH_BIT  11
`define ST_BYTE_LSB     16
`define EV_EOB_BIT      0
`define EV_SECT_BIT     1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_DESIRED     5'h00
`define RST_SHORT       1'b0

// ----------------------------------------
// Counts
// ----------------------------------------
`define WORD_BITS_16    5'h10
`define WORD_BITS_18    5'h12
`define HDR_WRITE_WORDS 3'h4
`define BYTE_SYNC_A16   10'h01e
`define BYTE_SYNC_A18   10'h024
`define BYTE_SYNC_B16   10'h027
`define BYTE_SYNC_B18   10'h02f
`define BYTE_END16      10'h1ff
`define BYTE_END18      10'h23f
`define EOB_SHIFT_TAP   6
`define DIBITS_22       10'h261
`define DIBITS_20       10'h2a0
`define SECTORS_22      5'h16
`define SECTORS_20      5'h14

`endif

// ==== common/sector_timing_pkg.sv ====
// Types of the sector timing core
package sector_timing_pkg;

	typedef enum logic [2:0] {
		CMD_IDLE,
		CMD_FORMAT,
		CMD_WRITE,
		CMD_READ_HDR,
		CMD_READ
	} cmd_t;

	typedef enum logic [1:0] {
		FIELD_GAP,
		FIELD_HEADER,
		FIELD_DATA
	} field_t;

	typedef struct packed {
		logic [2:0]  lk_sync;
		logic [2:0]  rs_sync;
		logic [2:0]  db_sync;
		logic        wstrobe;
		logic        shift_tick;
		logic [2:0]  bit_cnt;
		logic [4:0]  ring_cnt;
		logic [2:0]  hdr_words;
		logic        word_done;
		logic        hs_enable;
		logic        hs_pulse;
		logic        trail_clr;
		logic        bit0;
		logic        byte_tick;
		logic [9:0]  byte_cnt;
		logic [7:0]  byte_onehot;
		logic [7:0]  eob_sr;
		logic        sync_a;
		logic        sync_b;
		logic        end_cnt;
		logic        eob;
		logic [9:0]  dibit_cnt;
		logic        sect_raw;
		logic        sect_pulse;
		logic [4:0]  sect_cnt;
		logic        match;
		logic        located;
		cmd_t        cmd;
		field_t      field;
		logic        short_fmt;
		logic [4:0]  desired;
		logic        eob_seen;
		logic        sect_seen;
		logic        ack;
		logic [31:0] rdata;
	} state_t;

endpackage

// ==== verilog/sector_timing.sv ====
// Shift clock, word handshake, byte and sector timing core with a Wishbone slave
`timescale 1ns/1ps
`include "sector_timing_map.svh"

// Operation
// RQ1: Shift clock follows read strobe when read path selected, else locked clock.
// RQ2: Read path active for both reads and header part of write data.
// RQ3: Write strobe is the locked clock divided by two.
// RQ4: One handshake pulse per word, gated by the handshake enable flop.
// RQ5: Trailing edge of each handshake pulse clears the enable flop.
// RQ6: Ring counter runs on shift ticks only inside header or data window.
// RQ7: Full word sets word complete, which presets the enable flop.
// RQ8: Bit counter makes byte tick; it advances counter, one-hot and decode.
// RQ9: Bit zero tick marks first bit of each byte for sync insertion.
// RQ10: Byte count cleared at sector start and header and data field start.
// RQ11: One-hot byte register presets bit zero and shifts upward per byte.
// RQ12: Flag byte counts 30/36 and 39/47 for sync bytes.
// RQ13: Count 511/575 ends data; seven byte shifts later end of block.
// RQ14: Write gate allows enable in four format header words, all write data.
// RQ15: Read sector gate allows enable for each data word of reads.
// RQ16: Header read gate presets enable; header pulses only format or read-header.
// RQ17: Sector pulse after 609 di-bits in 22 format, 672 in 20.
// RQ18: Sector pulse once per sector clears byte count, clocks found flop.
// RQ19: Current sector number is five bits wide.
// RQ20: Match asserted when sector count equals desired sector register.
// RQ21: On match at sector pulse found flop sets, enabling header compare.
// RQ22: Offset bit 12 selects 16-bit format, else 18-bit mode.
// RQ23: Word length 16 shifts in 16-bit mode, 18 in 18-bit mode. The code uses 16 shifts for header words in both modes.
// RQ24: Sector counter wraps after 22 or 20 sectors.
// RQ25: Reset clears counters, enable and found flops; no handshake pulse.
module sector_timing (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Drive pins
	input  wire logic        locked_clock_in,
	input  wire logic        read_strobe_in,
	input  wire logic        dibit_pulse_in,
	output logic             write_strobe_out,
	// Controller side timing
	output logic             serial_shift_clock,
	output logic             word_handshake_clock_n,
	output logic             handshake_enable,
	output logic             read_path_select,
	output logic             bit_zero_tick,
	output logic             byte_tick,
	output logic             sync_byte_count_a,
	output logic             sync_byte_count_b,
	output logic             data_field_end_count,
	output logic             end_of_block_tick,
	// Sector position
	output logic             sector_pulse,
	output logic      [4:0]  current_sector_count,
	output logic             sector_match,
	output logic             sector_located
);

	sector_timing_pkg::state_t s;
	sector_timing_pkg::state_t n;

	logic       lk_rise;
	logic       rs_rise;
	logic       db_rise;
	logic       hdr;
	logic       dat;
	logic       window;
	logic       is_read;
	logic       is_wr;
	logic       rd_path;
	logic       write_path_gate;
	logic       read_sector_gate;
	logic       header_read_gate;
	logic       hs_set;
	logic       pulse_pass;
	logic [4:0] word_len;
	logic [9:0] dibit_lim;
	logic [4:0] sect_lim;
	logic       byte_count_clear;
	logic       req;
	logic       wr;
	logic       field_start;
	sector_timing_pkg::field_t new_field;

	// ----------------------------------------
	// Decode of mode and window
	// ----------------------------------------
	// Edges use stages two and three; stage one feeds only stage two
	assign lk_rise = s.lk_sync[1] & ~s.lk_sync[2];
	assign rs_rise = s.rs_sync[1] & ~s.rs_sync[2];
	assign db_rise = s.db_sync[1] & ~s.db_sync[2];

	assign hdr     = (s.field == sector_timing_pkg::FIELD_HEADER);
	assign dat     = (s.field == sector_timing_pkg::FIELD_DATA);
	assign window  = hdr | dat;
	assign is_read = (s.cmd == sector_timing_pkg::CMD_READ_HDR) |
	                 (s.cmd == sector_timing_pkg::CMD_READ);
	assign is_wr   = (s.cmd == sector_timing_pkg::CMD_FORMAT) |
	                 (s.cmd == sector_timing_pkg::CMD_WRITE);
	assign rd_path = is_read | ((s.cmd == sector_timing_pkg::CMD_WRITE) & hdr); // RQ2

	assign write_path_gate  = is_wr & ~rd_path & // RQ14
	                          ((hdr & (s.cmd == sector_timing_pkg::CMD_FORMAT) &
	                            (s.hdr_words < `HDR_WRITE_WORDS)) | dat);
	assign read_sector_gate = is_read & dat; // RQ15
	assign header_read_gate = hdr & (s.cmd != sector_timing_pkg::CMD_FORMAT) &
	                          (s.cmd != sector_timing_pkg::CMD_IDLE); // RQ16
	assign hs_set = s.word_done & (write_path_gate | read_sector_gate | header_read_gate);
	// Header reads still preset the flop so that word pacing stays intact
	assign pulse_pass = ~hdr | (s.cmd == sector_timing_pkg::CMD_FORMAT) |
	                    (s.cmd == sector_timing_pkg::CMD_READ_HDR); // RQ16

	// Header words are always 16 bits wide
	assign word_len  = (hdr | s.short_fmt) ? `WORD_BITS_16 : `WORD_BITS_18; // RQ22 RQ23
	assign dibit_lim = s.short_fmt ? `DIBITS_22 : `DIBITS_20;
	assign sect_lim  = s.short_fmt ? `SECTORS_22 : `SECTORS_20;

	assign req       = wb_cyc_i & wb_stb_i;
	assign wr        = req & wb_we_i & s.ack;
	assign new_field = sector_timing_pkg::field_t'(wb_dat_i[`CTRL_FIELD_LSB +: 2]);
	assign field_start = wr & (wb_adr_i == `ADR_CTRL) & wb_sel_i[0] &
	                     (new_field != s.field) &
	                     ((new_field == sector_timing_pkg::FIELD_HEADER) |
	                      (new_field == sector_timing_pkg::FIELD_DATA));
	assign byte_count_clear = s.sect_pulse | field_start; // RQ10 RQ18

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = s;
		n.lk_sync = {s.lk_sync[1:0], locked_clock_in};
		n.rs_sync = {s.rs_sync[1:0], read_strobe_in};
		n.db_sync = {s.db_sync[1:0], dibit_pulse_in};

		if (lk_rise) begin
			n.wstrobe = ~s.wstrobe; // RQ3
		end
		n.shift_tick = rd_path ? rs_rise : lk_rise; // RQ1

		// Word pacing
		n.word_done = 1'b0;
		n.trail_clr = 1'b0;
		if (!window) begin
			n.ring_cnt = 5'h00;
		end else if (s.shift_tick) begin
			if (s.ring_cnt == word_len - 5'h01) begin // RQ6 RQ23
				n.ring_cnt  = 5'h00;
				n.word_done = 1'b1; // RQ7
			end else begin
				n.ring_cnt = s.ring_cnt + 5'h01;
			end
		end
		if (s.word_done && hdr && s.hdr_words != 3'h7) begin
			n.hdr_words = s.hdr_words + 3'h1;
		end
		if (field_start) begin
			n.hdr_words = 3'h0;
		end
		if (s.shift_tick) begin
			if (s.hs_pulse) begin
				n.hs_pulse  = 1'b0;
				n.trail_clr = 1'b1; // RQ5
			end else if (s.hs_enable && !s.trail_clr) begin
				n.hs_pulse = 1'b1; // RQ4
			end
		end
		// Preset beats the trailing clear so a new word is never lost
		if (hs_set) begin
			n.hs_enable = 1'b1; // RQ7
		end else if (s.trail_clr) begin
			n.hs_enable = 1'b0; // RQ5
		end

		// Byte timing
		n.bit0      = s.shift_tick & (s.bit_cnt == 3'h0); // RQ9
		n.byte_tick = s.shift_tick & (s.bit_cnt == 3'h7); // RQ8
		n.sync_a    = 1'b0;
		n.sync_b    = 1'b0;
		n.end_cnt   = 1'b0;
		n.eob       = 1'b0;
		if (s.shift_tick) begin
			n.bit_cnt = s.bit_cnt + 3'h1;
		end
		if (s.byte_tick) begin
			n.byte_cnt    = s.byte_cnt + 10'h001; // RQ8
			n.byte_onehot = {s.byte_onehot[6:0], 1'b0}; // RQ11
			n.sync_a  = s.byte_cnt == (s.short_fmt ? `BYTE_SYNC_A16 : `BYTE_SYNC_A18); // RQ12
			n.sync_b  = s.byte_cnt == (s.short_fmt ? `BYTE_SYNC_B16 : `BYTE_SYNC_B18); // RQ12
			n.end_cnt = s.byte_cnt == (s.short_fmt ? `BYTE_END16 : `BYTE_END18); // RQ13
			n.eob_sr  = {s.eob_sr[6:0], n.end_cnt};
			n.eob     = s.eob_sr[`EOB_SHIFT_TAP]; // RQ13
		end
		if (byte_count_clear) begin
			n.bit_cnt     = 3'h0;
			n.byte_cnt    = 10'h000; // RQ10
			n.byte_onehot = 8'h01; // RQ11
			n.eob_sr      = 8'h00;
		end

		// Sector position
		n.sect_raw   = 1'b0;
		n.sect_pulse = s.sect_raw;
		if (db_rise) begin
			if (s.dibit_cnt >= dibit_lim - 10'h001) begin // RQ17
				n.dibit_cnt = 10'h000;
				n.sect_raw  = 1'b1;
			end else begin
				n.dibit_cnt = s.dibit_cnt + 10'h001;
			end
		end
		if (s.sect_raw) begin
			// Also recovers if the format shrinks mid-track
			n.sect_cnt = (s.sect_cnt >= sect_lim - 5'h01) ? 5'h00 : s.sect_cnt + 5'h01; // RQ24
		end
		n.match = (s.sect_cnt == s.desired); // RQ20
		if (s.sect_pulse) begin
			n.located = (s.sect_cnt == s.desired); // RQ21
		end

		// Register bus
		n.ack = req & ~s.ack;
		if (req && !s.ack) begin
			n.rdata = 32'h0000_0000;
			unique case (wb_adr_i)
				`ADR_CTRL: begin
					n.rdata[`CTRL_CMD_LSB +: 3]   = s.cmd;
					n.rdata[`CTRL_FIELD_LSB +: 2] = s.field;
				end
				`ADR_OFFSET:  n.rdata[`OFS_SHORT_BIT] = s.short_fmt;
				`ADR_DESIRED: n.rdata[4:0] = s.desired;
				`ADR_STATUS: begin
					n.rdata[4:0]                = s.sect_cnt;
					n.rdata[`ST_MATCH_BIT]      = s.match;
					n.rdata[`ST_LOCATED_BIT]    = s.located;
					n.rdata[`ST_HS_EN_BIT]      = s.hs_enable;
					n.rdata[`ST_RD_PATH_BIT]    = rd_path;
					n.rdata[`ST_BYTE_LSB +: 10] = s.byte_cnt;
				end
				`ADR_EVENTS: begin
					n.rdata[`EV_EOB_BIT]  = s.eob_seen;
					n.rdata[`EV_SECT_BIT] = s.sect_seen;
				end
				default: n.rdata = 32'h0000_0000;
			endcase
		end
		if (wr && wb_adr_i == `ADR_CTRL && wb_sel_i[0]) begin
			n.cmd   = sector_timing_pkg::cmd_t'(wb_dat_i[`CTRL_CMD_LSB +: 3]);
			n.field = new_field;
		end
		if (wr && wb_adr_i == `ADR_OFFSET && wb_sel_i[1]) begin
			n.short_fmt = wb_dat_i[`OFS_SHORT_BIT]; // RQ22
		end
		if (wr && wb_adr_i == `ADR_DESIRED && wb_sel_i[0]) begin
			n.desired = wb_dat_i[4:0];
		end
		// Write one to clear; a new event in the same cycle wins
		if (wr && wb_adr_i == `ADR_EVENTS && wb_sel_i[0]) begin
			if (wb_dat_i[`EV_EOB_BIT]) begin
				n.eob_seen = 1'b0;
			end
			if (wb_dat_i[`EV_SECT_BIT]) begin
				n.sect_seen = 1'b0;
			end
		end
		if (s.eob) begin
			n.eob_seen = 1'b1;
		end
		if (s.sect_pulse) begin
			n.sect_seen = 1'b1;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s             <= '0; // RQ25
			s.field       <= sector_timing_pkg::FIELD_GAP;
			s.cmd         <= sector_timing_pkg::CMD_IDLE;
			s.byte_onehot <= 8'h01;
			s.desired     <= `RST_DESIRED;
			s.short_fmt   <= `RST_SHORT;
			// Count and desired both reset to zero, so they already match
			s.match       <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_dat_o               = s.rdata;
	assign wb_ack_o               = s.ack;
	assign write_strobe_out       = s.wstrobe;
	assign serial_shift_clock     = s.shift_tick;
	assign word_handshake_clock_n = ~(s.hs_pulse & pulse_pass); // RQ4 RQ16
	assign handshake_enable       = s.hs_enable;
	assign read_path_select       = rd_path;
	assign bit_zero_tick          = s.bit0;
	assign byte_tick              = s.byte_tick;
	assign sync_byte_count_a      = s.sync_a;
	assign sync_byte_count_b      = s.sync_b;
	assign data_field_end_count   = s.end_cnt;
	assign end_of_block_tick      = s.eob;
	assign sector_pulse           = s.sect_pulse;
	assign current_sector_count   = s.sect_cnt; // RQ19
	assign sector_match           = s.match;
	assign sector_located         = s.located;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	a_strobe_divide: // RQ3
	assert property (lk_rise |=> write_strobe_out != $past(write_strobe_out))
		else $error("write strobe did not toggle on locked clock edge");

	a_shift_source: // RQ1
	assert property (rd_path && rs_rise |=> serial_shift_clock)
		else $error("shift tick missing on read strobe edge");

	a_read_path: // RQ2
	assert property (is_read |-> read_path_select)
		else $error("read path not selected during read command");

	a_word_length: // RQ23
	assert property (s.shift_tick && window && s.short_fmt && s.ring_cnt == 5'h0f
		|=> s.word_done)
		else $error("word complete not raised after 16 shifts");

	a_enable_preset: // RQ7
	assert property (hs_set |=> handshake_enable)
		else $error("handshake enable not preset by word complete");

	a_trail_clear: // RQ5
	assert property (s.trail_clr && !hs_set |=> !handshake_enable)
		else $error("handshake enable not cleared after pulse");

	a_header_quiet: // RQ16
	assert property (hdr && s.cmd == sector_timing_pkg::CMD_READ |-> word_handshake_clock_n)
		else $error("handshake pulse issued during read-data header");

	a_onehot_count: // RQ11
	assert property ($onehot0(s.byte_onehot))
		else $error("byte count register not one-hot");

	a_sector_clear: // RQ18
	assert property (sector_pulse |=> s.byte_cnt == 10'h000 && s.byte_onehot == 8'h01)
		else $error("byte count not cleared by sector pulse");

	a_sector_wrap: // RQ24
	assert property (current_sector_count < `SECTORS_22)
		else $error("sector count beyond last sector");

	a_match_follow: // RQ20
	assert property (##1 sector_match == ($past(s.sect_cnt) == $past(s.desired)))
		else $error("sector match does not follow comparison");

	a_found_set: // RQ21
	assert property (sector_pulse && s.sect_cnt == s.desired |=> sector_located)
		else $error("sector found not set on match");

endmodule
